// >>> rtl/eac_pkg.sv
// Shared constants, types and helpers for the nonvolatile access controller.
package eac_pkg;

	// Core-side I/O register offsets and control bit positions.
	localparam int unsigned    EAC_IO_AW      = 6;
	localparam logic [5:0]     EAC_OFF_CTRL   = 6'h1C;
	localparam logic [5:0]     EAC_OFF_DATA   = 6'h1D;
	localparam logic [5:0]     EAC_OFF_ADDR   = 6'h1E;
	localparam int unsigned    EAC_BIT_RS     = 0;
	localparam int unsigned    EAC_BIT_PE     = 1;
	localparam int unsigned    EAC_BIT_MPE    = 2;
	localparam int unsigned    EAC_BIT_RIE    = 3;
	localparam int unsigned    EAC_BIT_MODE   = 4;
	localparam logic [7:0]     EAC_DATA_RST   = 8'h00;
	localparam logic [7:0]     EAC_ADDR_RST   = 8'h00;
	localparam logic [7:0]     EAC_ERASED     = 8'hFF;
	localparam int unsigned    EAC_NVM_DEPTH  = 256;

	// Programming modes.
	typedef enum logic [1:0] {
		EAC_MODE_ATOMIC = 2'h0,
		EAC_MODE_ERASE  = 2'h1,
		EAC_MODE_WRITE  = 2'h2,
		EAC_MODE_RSVD   = 2'h3
	} eac_mode_t;

	// Stall and arming windows in core clock cycles.
	localparam logic [2:0]     EAC_READ_STALL = 3'h4;
	localparam logic [2:0]     EAC_PROG_STALL = 3'h2;
	localparam logic [2:0]     EAC_MPE_WINDOW = 3'h4;

	// Programming times, rounded up to whole cycles of the 4 ns clock.
	localparam int unsigned    EAC_CLK_NS     = 4;
	localparam int unsigned    EAC_T_ATOMIC_NS = 3400000;
	localparam int unsigned    EAC_T_SPLIT_NS = 1800000;
	localparam int unsigned    EAC_ATOMIC_CYC = (EAC_T_ATOMIC_NS + EAC_CLK_NS - 1) / EAC_CLK_NS;
	localparam int unsigned    EAC_SPLIT_CYC  = (EAC_T_SPLIT_NS + EAC_CLK_NS - 1) / EAC_CLK_NS;
	localparam int unsigned    EAC_TMR_W      = 20;

	// Controller APB map and command fields.
	localparam logic [11:0]    EAC_APB_CMD    = 12'h000;
	localparam logic [11:0]    EAC_APB_STAT   = 12'h004;
	localparam int unsigned    EAC_CMD_OP     = 0;
	localparam int unsigned    EAC_CMD_ADDR   = 8;
	localparam int unsigned    EAC_CMD_DATA   = 16;
	localparam int unsigned    EAC_CMD_GO     = 31;
	localparam int unsigned    EAC_ST_ACTIVE  = 0;
	localparam int unsigned    EAC_ST_DONE    = 1;
	localparam int unsigned    EAC_ST_READY   = 2;
	localparam int unsigned    EAC_ST_RDATA   = 8;

	typedef enum logic [1:0] {
		EAC_OP_READ   = 2'h0,
		EAC_OP_ATOMIC = 2'h1,
		EAC_OP_ERASE  = 2'h2,
		EAC_OP_WRONLY = 2'h3
	} eac_op_t;

	// Builds a control register byte; interrupt enable is left at zero.
	function automatic logic [7:0] eac_ctrl_byte(input eac_mode_t mode, input logic mpe,
		input logic pe, input logic rs);
		logic [7:0] b;
		b = 8'h00;
		b[EAC_BIT_MODE +: 2] = mode;
		b[EAC_BIT_MPE] = mpe;
		b[EAC_BIT_PE] = pe;
		b[EAC_BIT_RS] = rs;
		return b;
	endfunction

endpackage

// >>> rtl/eac_io_if.sv
// Core I/O register port between the processor side and the access controller.
`timescale 1ns/1ps
interface eac_io_if;
	import eac_pkg::*;
	logic                 wr;
	logic                 rd;
	logic [EAC_IO_AW-1:0] addr;
	logic [7:0]           wdata;
	logic [7:0]           rdata;
	logic                 rvalid;
	logic                 stall;
	logic                 ready_irq;

	modport dev  (input wr, input rd, input addr, input wdata,
		output rdata, output rvalid, output stall, output ready_irq);
	modport host (output wr, output rd, output addr, output wdata,
		input rdata, input rvalid, input stall, input ready_irq);
endinterface

// >>> rtl/eac_nvm_dev.sv
// Data EEPROM access controller with its 256-byte array, core I/O side.
`timescale 1ns/1ps
module eac_nvm_dev
	import eac_pkg::*;
#(
	parameter int unsigned T_ATOMIC_CYC = EAC_ATOMIC_CYC,
	parameter int unsigned T_SPLIT_CYC  = EAC_SPLIT_CYC
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic por_n,
	eac_io_if.dev     io
);

	logic [7:0]           mem_r [EAC_NVM_DEPTH];
	logic [7:0]           addr_r;
	logic [7:0]           data_r;
	logic                 rie_r;
	logic                 mpe_r;
	logic [2:0]           mpe_cnt_r;
	logic [2:0]           stall_cnt_r;
	logic [7:0]           rdata_r;
	logic                 rvalid_r;
	eac_mode_t            mode_r;
	logic                 busy_r;
	logic [EAC_TMR_W-1:0] timer_r;
	eac_mode_t            op_mode_r;
	logic [7:0]           op_addr_r;
	logic [7:0]           op_data_r;
	logic                 rst_s1_r;
	logic                 rst_s2_r;
	logic                 acc_ok;
	logic                 wr_ctrl;
	logic                 wr_data;
	logic                 wr_addr;
	logic                 start;
	logic                 rd_go;
	logic                 prog_done;

	// New byte after an operation; write-only can only clear bits of the stored byte, erased or not.
	function automatic logic [7:0] eac_program(input logic [7:0] old, input logic [7:0] d,
		input eac_mode_t m);
		case (m)
			EAC_MODE_ATOMIC: eac_program = d;
			EAC_MODE_ERASE:  eac_program = EAC_ERASED;
			EAC_MODE_WRITE:  eac_program = old & d;
			default:         eac_program = old;
		endcase
	endfunction

	// The core is halted while a stall runs, so accesses are taken only outside one.
	assign acc_ok    = (stall_cnt_r == 3'h0);
	assign wr_ctrl   = io.wr && acc_ok && (io.addr == EAC_OFF_CTRL);
	assign wr_data   = io.wr && acc_ok && (io.addr == EAC_OFF_DATA);
	assign wr_addr   = io.wr && acc_ok && (io.addr == EAC_OFF_ADDR);
	assign start     = wr_ctrl && io.wdata[EAC_BIT_PE] && mpe_r && !busy_r
		&& (mode_r != EAC_MODE_RSVD);
	assign rd_go     = wr_ctrl && io.wdata[EAC_BIT_RS] && !busy_r && !start;
	assign prog_done = busy_r && (timer_r == '0);

	assign io.stall     = !acc_ok;
	assign io.ready_irq = rie_r && !busy_r;
	assign io.rdata     = rdata_r;
	assign io.rvalid    = rvalid_r;

	// Core reset is brought into the clock domain so the mode field can honour it
	// without being cleared under a running operation.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= resetn;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Mode field lives on the power-on reset so a busy array keeps its mode.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			mode_r <= EAC_MODE_ATOMIC;
		end else if (!rst_s2_r && !busy_r) begin
			mode_r <= EAC_MODE_ATOMIC;
		end else if (wr_ctrl && !busy_r) begin
			mode_r <= eac_mode_t'(io.wdata[EAC_BIT_MODE +: 2]);
		end
	end

	// Programming engine; only power-on reset stops it.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			busy_r    <= 1'b0;
			timer_r   <= '0;
			op_mode_r <= EAC_MODE_ATOMIC;
			op_addr_r <= EAC_ADDR_RST;
			op_data_r <= EAC_DATA_RST;
		end else if (start) begin
			busy_r    <= 1'b1;
			op_mode_r <= mode_r;
			op_addr_r <= addr_r;
			op_data_r <= data_r;
			if (mode_r == EAC_MODE_ATOMIC) begin
				timer_r <= EAC_TMR_W'(T_ATOMIC_CYC - 1);
			end else begin
				timer_r <= EAC_TMR_W'(T_SPLIT_CYC - 1);
			end
		end else if (prog_done) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			timer_r <= timer_r - 1'b1;
		end
	end

	// The array itself holds no reset, like the cells it models.
	always_ff @(posedge clk) begin
		if (prog_done) begin
			mem_r[op_addr_r] <= eac_program(mem_r[op_addr_r], op_data_r, op_mode_r);
		end
	end

	// Address and data registers; locked while programming.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_r <= EAC_ADDR_RST;
			data_r <= EAC_DATA_RST;
		end else begin
			if (wr_addr && !busy_r) begin
				addr_r <= io.wdata;
			end
			if (rd_go) begin
				data_r <= mem_r[addr_r];
			end else if (wr_data && !busy_r) begin
				data_r <= io.wdata;
			end
		end
	end

	// Interrupt enable and the four-cycle master enable window.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rie_r     <= 1'b0;
			mpe_r     <= 1'b0;
			mpe_cnt_r <= 3'h0;
		end else if (wr_ctrl) begin
			rie_r     <= io.wdata[EAC_BIT_RIE];
			mpe_r     <= io.wdata[EAC_BIT_MPE] && !start;
			mpe_cnt_r <= EAC_MPE_WINDOW;
		end else if (mpe_r) begin
			mpe_cnt_r <= mpe_cnt_r - 3'h1;
			if (mpe_cnt_r == 3'h1) begin
				mpe_r <= 1'b0;
			end
		end
	end

	// Core stall counter for reads and program starts.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stall_cnt_r <= 3'h0;
		end else if (rd_go) begin
			stall_cnt_r <= EAC_READ_STALL;
		end else if (start) begin
			stall_cnt_r <= EAC_PROG_STALL;
		end else if (!acc_ok) begin
			stall_cnt_r <= stall_cnt_r - 3'h1;
		end
	end

	// Read port: answer one cycle after the request; unmapped offsets read zero.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= io.rd && acc_ok;
			if (io.rd && acc_ok) begin
				case (io.addr)
					EAC_OFF_CTRL: rdata_r <= {2'b00, mode_r, rie_r, mpe_r, busy_r, 1'b0};
					EAC_OFF_DATA: rdata_r <= data_r;
					EAC_OFF_ADDR: rdata_r <= addr_r;
					default:      rdata_r <= 8'h00;
				endcase
			end
		end
	end

endmodule

// >>> rtl/eac_nvm_host.sv
// Processor-side sequencer: takes APB commands and runs the access procedures.
`timescale 1ns/1ps
module eac_nvm_host
	import eac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	eac_io_if.host           io
);

	typedef enum logic [3:0] {
		EAC_S_IDLE   = 4'h0,
		EAC_S_POLL   = 4'h1,
		EAC_S_POLL_W = 4'h3,
		EAC_S_MODE   = 4'h2,
		EAC_S_ADDR   = 4'h6,
		EAC_S_DATA   = 4'h7,
		EAC_S_MPE    = 4'h5,
		EAC_S_PE     = 4'h4,
		EAC_S_RS     = 4'hC,
		EAC_S_RD     = 4'hD,
		EAC_S_RD_W   = 4'hF
	} eac_hstate_t;

	eac_hstate_t state_r;
	eac_op_t     op_r;
	eac_mode_t   mode;
	logic [7:0]  a_r;
	logic [7:0]  d_r;
	logic [7:0]  rbyte_r;
	logic        done_r;
	logic [31:0] prdata_r;
	logic        wr_r;
	logic        rd_r;
	logic [5:0]  ioaddr_r;
	logic [7:0]  iowdata_r;
	logic        can_issue;
	logic        mapped;
	logic        cmd_go;

	assign mapped    = (paddr == EAC_APB_CMD) || (paddr == EAC_APB_STAT);
	assign cmd_go    = psel && penable && pwrite && (paddr == EAC_APB_CMD)
		&& pwdata[EAC_CMD_GO] && (state_r == EAC_S_IDLE);
	// One outstanding access at a time, and none while the device halts the core.
	assign can_issue = !io.stall && !wr_r && !rd_r;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_r;
	assign io.wr     = wr_r;
	assign io.rd     = rd_r;
	assign io.addr   = ioaddr_r;
	assign io.wdata  = iowdata_r;

	always_comb begin
		case (op_r)
			EAC_OP_ERASE:  mode = EAC_MODE_ERASE;
			EAC_OP_WRONLY: mode = EAC_MODE_WRITE;
			default:       mode = EAC_MODE_ATOMIC;
		endcase
	end

	// APB read data is captured in the setup cycle and stands through the access.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_r <= 32'h0000_0000;
			if (paddr == EAC_APB_STAT) begin
				prdata_r[EAC_ST_ACTIVE]    <= (state_r != EAC_S_IDLE);
				prdata_r[EAC_ST_DONE]      <= done_r;
				prdata_r[EAC_ST_READY]     <= io.ready_irq;
				prdata_r[EAC_ST_RDATA +: 8] <= rbyte_r;
			end
		end
	end

	// Command sequencer and the one-cycle access pulses it issues.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r   <= EAC_S_IDLE;
			op_r      <= EAC_OP_READ;
			a_r       <= 8'h00;
			d_r       <= 8'h00;
			rbyte_r   <= 8'h00;
			done_r    <= 1'b0;
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			ioaddr_r  <= EAC_OFF_CTRL;
			iowdata_r <= 8'h00;
		end else begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			case (state_r)
				EAC_S_IDLE: begin
					if (cmd_go) begin
						op_r    <= eac_op_t'(pwdata[EAC_CMD_OP +: 2]);
						a_r     <= pwdata[EAC_CMD_ADDR +: 8];
						d_r     <= pwdata[EAC_CMD_DATA +: 8];
						done_r  <= 1'b0;
						state_r <= EAC_S_POLL;
					end
				end
				EAC_S_POLL: begin
					if (can_issue) begin
						rd_r     <= 1'b1;
						ioaddr_r <= EAC_OFF_CTRL;
						state_r  <= EAC_S_POLL_W;
					end
				end
				EAC_S_POLL_W: begin
					if (io.rvalid) begin
						if (io.rdata[EAC_BIT_PE]) begin
							state_r <= EAC_S_POLL;
						end else if (op_r == EAC_OP_READ) begin
							state_r <= EAC_S_ADDR;
						end else begin
							state_r <= EAC_S_MODE;
						end
					end
				end
				EAC_S_MODE: begin
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_CTRL;
						iowdata_r <= eac_ctrl_byte(mode, 1'b0, 1'b0, 1'b0);
						state_r   <= EAC_S_ADDR;
					end
				end
				EAC_S_ADDR: begin
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_ADDR;
						iowdata_r <= a_r;
						state_r   <= (op_r == EAC_OP_READ) ? EAC_S_RS : EAC_S_DATA;
					end
				end
				EAC_S_DATA: begin
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_DATA;
						iowdata_r <= d_r;
						state_r   <= EAC_S_MPE;
					end
				end
				EAC_S_MPE: begin
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_CTRL;
						iowdata_r <= eac_ctrl_byte(mode, 1'b1, 1'b0, 1'b0);
						state_r   <= EAC_S_PE;
					end
				end
				EAC_S_PE: begin
					// Issued two cycles after arming, well inside the window.
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_CTRL;
						iowdata_r <= eac_ctrl_byte(mode, 1'b1, 1'b1, 1'b0);
						done_r    <= 1'b1;
						state_r   <= EAC_S_IDLE;
					end
				end
				EAC_S_RS: begin
					if (can_issue) begin
						wr_r      <= 1'b1;
						ioaddr_r  <= EAC_OFF_CTRL;
						iowdata_r <= eac_ctrl_byte(EAC_MODE_ATOMIC, 1'b0, 1'b0, 1'b1);
						state_r   <= EAC_S_RD;
					end
				end
				EAC_S_RD: begin
					if (can_issue) begin
						rd_r     <= 1'b1;
						ioaddr_r <= EAC_OFF_DATA;
						state_r  <= EAC_S_RD_W;
					end
				end
				EAC_S_RD_W: begin
					if (io.rvalid) begin
						rbyte_r <= io.rdata;
						done_r  <= 1'b1;
						state_r <= EAC_S_IDLE;
					end
				end
				default: begin
					state_r <= EAC_S_IDLE;
				end
			endcase
		end
	end

endmodule

// >>> dv/eac_io_monitor.sv
// Concurrent checks on the core I/O port that joins the sequencer and the array end.
`timescale 1ns/1ps
module eac_io_monitor
	import eac_pkg::*;
#(
	parameter int unsigned T_ATOMIC_CYC = EAC_ATOMIC_CYC,
	parameter int unsigned T_SPLIT_CYC  = EAC_SPLIT_CYC
) (
	input wire logic                 clk,
	input wire logic                 resetn,
	input wire logic                 wr,
	input wire logic                 rd,
	input wire logic [EAC_IO_AW-1:0] addr,
	input wire logic [7:0]           wdata,
	input wire logic [7:0]           rdata,
	input wire logic                 rvalid,
	input wire logic                 stall,
	input wire logic                 ready_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// The busy countdown ignores core reset, since a running operation survives it.
	// It runs three cycles longer than the operation so that a one-cycle skew never fires the idle check.
	logic        ctrl_wr;
	logic        ctrl_rd;
	logic        pe_q_r     = 1'b0;
	logic [1:0]  pe_mode_r  = 2'h0;
	logic [1:0]  run_mode_r = 2'h0;
	logic [20:0] left_r     = 21'h0_0000;
	logic        rd_ctrl_r;
	logic [3:0]  mpe_age_r;

	assign ctrl_wr = wr && !stall && (addr == EAC_OFF_CTRL);
	assign ctrl_rd = rvalid && rd_ctrl_r;

	always_ff @(posedge clk) begin
		pe_q_r <= ctrl_wr && wdata[EAC_BIT_PE] && !wdata[EAC_BIT_RS];
		if (ctrl_wr && wdata[EAC_BIT_PE]) begin
			pe_mode_r <= wdata[EAC_BIT_MODE +: 2];
		end
	end

	always_ff @(posedge clk) begin
		if (pe_q_r && stall) begin
			left_r     <= (pe_mode_r == 2'h0) ? 21'(T_ATOMIC_CYC + 3) : 21'(T_SPLIT_CYC + 3);
			run_mode_r <= pe_mode_r;
		end else if (left_r != 21'h0_0000) begin
			left_r <= left_r - 21'h0_0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ctrl_r <= 1'b0;
		end else begin
			rd_ctrl_r <= rd && !stall && (addr == EAC_OFF_CTRL);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mpe_age_r <= 4'hF;
		end else if (ctrl_wr && wdata[EAC_BIT_MPE] && !wdata[EAC_BIT_PE]) begin
			mpe_age_r <= 4'h0;
		end else if (mpe_age_r != 4'hF) begin
			mpe_age_r <= mpe_age_r + 4'h1;
		end
	end

	sequence s_strobe;
		ctrl_wr && wdata[EAC_BIT_RS];
	endsequence
	sequence s_pe_start;
		ctrl_wr && wdata[EAC_BIT_PE] && !wdata[EAC_BIT_RS] ##1 stall;
	endsequence

	property p_read_stall;
		s_strobe |=> stall [*4] ##1 !stall;
	endproperty
	property p_rvalid;
		rvalid == $past(rd && !stall);
	endproperty
	property p_prog_stall;
		s_pe_start |=> stall ##1 !stall;
	endproperty
	property p_mpe_guard;
		ctrl_wr && wdata[EAC_BIT_PE] && !wdata[EAC_BIT_RS] && (mpe_age_r > 4'h8) |=> !stall;
	endproperty
	property p_busy_held;
		ctrl_rd && (left_r > 21'h0_0004) |-> rdata[EAC_BIT_PE];
	endproperty
	property p_idle_clear;
		ctrl_rd && (left_r == 21'h0_0000) |-> !rdata[EAC_BIT_PE];
	endproperty
	property p_mode_hold;
		ctrl_rd && (left_r > 21'h0_0004) |-> rdata[EAC_BIT_MODE +: 2] == run_mode_r;
	endproperty
	property p_ctrl_bits;
		ctrl_rd |-> (rdata[EAC_BIT_RS] == 1'b0) && (rdata[7:6] == 2'h0);
	endproperty
	property p_irq_busy;
		(left_r > 21'h0_0004) |-> !ready_irq;
	endproperty

	a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");
	a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
	a_prog_stall: assert property (p_prog_stall) else $error("program stall length wrong");
	a_mpe_guard: assert property (p_mpe_guard) else $error("start without arming");
	a_busy_held: assert property (p_busy_held) else $error("busy dropped early");
	a_idle_clear: assert property (p_idle_clear) else $error("busy stuck after end");
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy");
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("strobe or spare bit set");
	a_irq_busy: assert property (p_irq_busy) else $error("ready request while busy");
endmodule

// >>> dv/eeprom_access_controller_bench.sv
// Bench: APB sequencer facing one array end, and a second array end driven directly.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[FAIL] %0t got %0h expected %0h", $time, (g), (e)); \
	end \
end
module eeprom_access_controller_bench
	import eac_pkg::*;
;
	localparam int unsigned TA = 40;
	localparam int unsigned TS = 20;
	logic        clk        = 1'b0;
	logic        resetn     = 1'b0;
	logic        por_n      = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [11:0] paddr      = 12'h000;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          n_checks   = 0;
	int          fail_count = 0;

	eac_io_if io ();
	eac_io_if io2 ();

	eac_nvm_host u_eac_nvm_host (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .io(io));
	eac_nvm_dev #(.T_ATOMIC_CYC(TA), .T_SPLIT_CYC(TS)) u_eac_nvm_dev (.clk(clk),
		.resetn(resetn), .por_n(por_n), .io(io));
	eac_nvm_dev #(.T_ATOMIC_CYC(TA), .T_SPLIT_CYC(TS)) u_eac_nvm_dev_2 (.clk(clk),
		.resetn(resetn), .por_n(por_n), .io(io2));
	eac_io_monitor #(.T_ATOMIC_CYC(TA), .T_SPLIT_CYC(TS)) u_eac_io_monitor (.clk(clk),
		.resetn(resetn), .wr(io.wr), .rd(io.rd), .addr(io.addr), .wdata(io.wdata),
		.rdata(io.rdata), .rvalid(io.rvalid), .stall(io.stall), .ready_irq(io.ready_irq));

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits for the sequencer to finish, so busy may still be running on return.
	task automatic cmd(input eac_op_t op, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] st);
		logic e;
		apb(1'b1, EAC_APB_CMD, {1'b1, 7'h00, d, a, 6'h00, op}, st, e);
		// A sequencer that never finishes is caught by the watchdog.
		do begin
			apb(1'b0, EAC_APB_STAT, 32'h0000_0000, st, e);
		end while (st[EAC_ST_ACTIVE] !== 1'b0 || st[EAC_ST_DONE] !== 1'b1);
	endtask

	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		while (io2.stall !== 1'b0) @(negedge clk);
		@(posedge clk);
		io2.wr    <= 1'b1;
		io2.addr  <= a;
		io2.wdata <= d;
		@(posedge clk);
		io2.wr    <= 1'b0;
	endtask

	task automatic io_rd(input logic [5:0] a, output logic [7:0] q);
		@(negedge clk);
		while (io2.stall !== 1'b0) @(negedge clk);
		@(posedge clk);
		io2.rd   <= 1'b1;
		io2.addr <= a;
		@(posedge clk);
		io2.rd   <= 1'b0;
		@(negedge clk);
		`CHK(io2.rvalid, 1'b1)
		q = io2.rdata;
	endtask

	task automatic t_guard();
		logic [7:0] q;
		io_rd(EAC_OFF_DATA, q);
		`CHK(q, 8'h00)
		io_wr(EAC_OFF_ADDR, 8'h07);
		io_wr(EAC_OFF_CTRL, 8'h34);
		io_wr(EAC_OFF_CTRL, 8'h36);
		io_rd(EAC_OFF_CTRL, q);
		`CHK(q[EAC_BIT_PE], 1'b0)
		// Disarm first, so only the missing master enable can block this start.
		io_wr(EAC_OFF_CTRL, 8'h10);
		io_wr(EAC_OFF_CTRL, 8'h12);
		io_rd(EAC_OFF_CTRL, q);
		`CHK(q[EAC_BIT_PE], 1'b0)
	endtask

	task automatic t_lock();
		logic [7:0] q;
		int         n;
		io_wr(EAC_OFF_CTRL, 8'h08);
		@(negedge clk);
		`CHK(io2.ready_irq, 1'b1)
		io_wr(EAC_OFF_ADDR, 8'h05);
		io_wr(EAC_OFF_CTRL, 8'h1C);
		io_wr(EAC_OFF_CTRL, 8'h1E);
		@(negedge clk);
		`CHK(io2.ready_irq, 1'b0)
		io_wr(EAC_OFF_ADDR, 8'h06);
		io_wr(EAC_OFF_CTRL, 8'h28);
		io_rd(EAC_OFF_ADDR, q);
		`CHK(q, 8'h05)
		io_rd(EAC_OFF_CTRL, q);
		`CHK(q[EAC_BIT_MODE +: 2], 2'h1)
		`CHK(q[EAC_BIT_PE], 1'b1)
		n = 0;
		while (io2.ready_irq !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		`CHK(io2.ready_irq, 1'b1)
		io_wr(EAC_OFF_CTRL, 8'h09);
		io_rd(EAC_OFF_DATA, q);
		`CHK(q, 8'hFF)
	endtask

	task automatic t_atomic();
		logic [7:0]  al [3] = '{8'h00, 8'hFF, 8'h80};
		logic [31:0] st;
		foreach (al[i]) begin
			cmd(EAC_OP_ATOMIC, al[i], al[i] ^ 8'h5A, st);
			`CHK(st[EAC_ST_READY], 1'b0)
			cmd(EAC_OP_READ, al[i], 8'h00, st);
			`CHK(st[EAC_ST_RDATA +: 8], al[i] ^ 8'h5A)
		end
	endtask

	task automatic t_split();
		logic [31:0] st;
		cmd(EAC_OP_ERASE, 8'h10, 8'h00, st);
		cmd(EAC_OP_READ, 8'h10, 8'h00, st);
		`CHK(st[EAC_ST_RDATA +: 8], 8'hFF)
		cmd(EAC_OP_WRONLY, 8'h10, 8'h3C, st);
		cmd(EAC_OP_READ, 8'h10, 8'h00, st);
		`CHK(st[EAC_ST_RDATA +: 8], 8'h3C)
		cmd(EAC_OP_WRONLY, 8'h10, 8'hC3, st);
		cmd(EAC_OP_READ, 8'h10, 8'h00, st);
		`CHK(st[EAC_ST_RDATA +: 8], 8'h00)
	endtask

	task automatic t_unmapped();
		logic [31:0] q;
		logic        e;
		apb(1'b0, 12'h008, 32'h0000_0000, q, e);
		`CHK(e, 1'b1)
		apb(1'b0, EAC_APB_STAT, 32'h0000_0000, q, e);
		`CHK(e, 1'b0)
	endtask

	task automatic t_reset();
		logic [31:0] st;
		cmd(EAC_OP_ATOMIC, 8'h20, 8'hA5, st);
		repeat (5) @(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		cmd(EAC_OP_READ, 8'h20, 8'h00, st);
		`CHK(st[EAC_ST_RDATA +: 8], 8'hA5)
	endtask

	initial begin
		io2.wr    = 1'b0;
		io2.rd    = 1'b0;
		io2.addr  = 6'h00;
		io2.wdata = 8'h00;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		por_n  <= 1'b1;
		t_guard();
		t_lock();
		t_atomic();
		t_split();
		t_unmapped();
		t_reset();
		wrap_up();
	end

	// Whole run needs well under twenty thousand cycles.
	initial begin
		#80000;
		fail_count++;
		wrap_up();
	end
endmodule
